// ==== rtl/rac_alarm_match.v ====
// Masked alarm detector for the auxiliary relay.
// Assumes flags and masks aligned bit for bit; purely combinational.
`timescale 1ns/1ps
`default_nettype none

module rac_alarm_match #(
    parameter N = 6
) (
    // Alarm flags and their masks
    input  wire [N-1:0] flags_i,
    input  wire [N-1:0] masks_i,
    // Any unmasked flag set
    output wire         hit_o
);

    wire [N-1:0] gated;

    genvar g;
    generate
        for (g = 0; g < N; g = g + 1) begin : g_gate
            // A zero mask removes the flag from activation
            assign gated[g] = flags_i[g] & masks_i[g];
        end
    endgenerate

    assign hit_o = |gated;

endmodule

`default_nettype wire

// ==== rtl/rac_consts.vh ====
// Constants for the auxiliary relay control block.
// Assumes inclusion by bare name from the rtl/ folder.
`ifndef RAC_CONSTS_VH
`define RAC_CONSTS_VH

// Holding-register location of the relay configuration register
`define RAC_RELAY_CONFIG_ADDR   16'h0010
// Input-register location of the controller status register
`define RAC_CTRL_STATUS_ADDR    16'h0100

// Field positions in the relay configuration register
`define RAC_MANUAL_BIT          0
`define RAC_FUNC_BIT            1
`define RAC_MASK_LSB            2
`define RAC_MASK_MSB            7

// Number of alarm sources
`define RAC_NUM_ALARMS          6

// Reset value: bits 15..8 zero, 7..1 one, 0 zero
`define RAC_RELAY_CONFIG_RST    16'h00FE
// Bits that a write may change
`define RAC_RELAY_CONFIG_WMASK  16'h00FF

`endif

// ==== rtl/rac_relay_ctrl.v ====
// Auxiliary relay controller: configuration register and relay drive.
// Assumes a register-protocol front end supplying one-cycle word
// writes and reads by register location, and status flags synchronous
// to clk_i.
//
// Operation
// - Relay config at holding location 16, resets to 0x00FE.
// - After reset the relay acts as an alarm relay.
// - Bit 1 selects mode: 0 manual, 1 masked alarm.
// - Manual mode: bit 0 low de-energises, high energises the relay.
// - Manual state bit has no effect in alarm mode.
// - Bits 2 to 7 mask status flags at the same positions.
// - Alarm mode energises relay when any unmasked flag is set.
// - A flag with mask zero never activates the relay.
// - Exactly six alarm sources feed the relay.
// - Writes to bits 8 to 15 are ignored; host writes zeros.
// - Flags come from controller status bits 2 to 7.
`timescale 1ns/1ps
`default_nettype none
`include "rac_consts.vh"

module rac_relay_ctrl #(
    parameter AW = 16,
    parameter DW = 16
) (
    // Clock and reset
    input  wire          clk_i,
    input  wire          rst_i,
    // Holding-register access from the protocol front end
    input  wire          reg_wr_i,
    input  wire          reg_rd_i,
    input  wire [AW-1:0] reg_addr_i,
    input  wire [DW-1:0] reg_wdata_i,
    output reg  [DW-1:0] reg_rdata_o,
    output reg           reg_ack_o,
    output reg           reg_err_o,
    // Alarm sources, one per flag
    input  wire          internal_fault_flag_i,
    input  wire          host_link_fault_flag_i,
    input  wire          chain_bus_fault_flag_i,
    input  wire          device_limit_fault_flag_i,
    input  wire          device_mismatch_fault_flag_i,
    input  wire          termination_fault_flag_i,
    // Relay coil drive, high energises (common to normally-open)
    output reg           aux_relay_o,
    // Copy of the configuration for status visibility
    output reg  [DW-1:0] relay_config_o
);

    ////////////////////////////////////////////////////////////////////
    // Declarations

    // Register constants sized to the bus so no bits are dropped silently
    localparam [AW-1:0] CFG_ADDR  = `RAC_RELAY_CONFIG_ADDR;
    localparam [DW-1:0] CFG_RST   = `RAC_RELAY_CONFIG_RST;
    localparam [DW-1:0] CFG_WMASK = `RAC_RELAY_CONFIG_WMASK;
    localparam          NA        = `RAC_NUM_ALARMS;

    // Stored configuration and its next value
    reg  [DW-1:0] relay_config_r;
    reg  [DW-1:0] relay_config_nxt;
    // Access decode
    wire          access_req;
    wire          hit_sel;
    wire          wr_hit;
    wire          rd_hit;
    // Configuration fields
    wire          relay_manual_state;
    wire          relay_function_select;
    wire [NA-1:0] masks;
    // Alarm path
    wire [NA-1:0] flags;
    wire          hit;
    reg           aux_relay_nxt;
    // Bus answer, settled ahead of the output flops
    reg           reg_ack_nxt;
    reg           reg_err_nxt;
    reg  [DW-1:0] reg_rdata_nxt;

    ////////////////////////////////////////////////////////////////////
    // Access decode

    assign access_req = reg_wr_i | reg_rd_i;
    assign hit_sel    = (reg_addr_i == CFG_ADDR);
    assign wr_hit     = reg_wr_i & hit_sel;
    assign rd_hit     = reg_rd_i & hit_sel;

    ////////////////////////////////////////////////////////////////////
    // Configuration register

    // Upper byte is cleared by the write mask, so it always reads back as zero
    always @* begin
        relay_config_nxt = relay_config_r;
        if (wr_hit) begin
            relay_config_nxt = reg_wdata_i & CFG_WMASK;
        end
    end

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            relay_config_r <= CFG_RST;
        end else begin
            relay_config_r <= relay_config_nxt;
        end
    end

    // Named fields of the stored word
    assign relay_manual_state    = relay_config_r[`RAC_MANUAL_BIT];
    assign relay_function_select = relay_config_r[`RAC_FUNC_BIT];
    assign masks                 = relay_config_r[`RAC_MASK_MSB:`RAC_MASK_LSB];

    ////////////////////////////////////////////////////////////////////
    // Alarm matching

    // Order matches status bits 2..7 so one mask slice lines up
    assign flags = {termination_fault_flag_i,
                    device_mismatch_fault_flag_i,
                    device_limit_fault_flag_i,
                    chain_bus_fault_flag_i,
                    host_link_fault_flag_i,
                    internal_fault_flag_i};

    rac_alarm_match #(
        .N (NA)
    ) u_match (
        .flags_i (flags),
        .masks_i (masks),
        .hit_o   (hit)
    );

    ////////////////////////////////////////////////////////////////////
    // Relay source select

    // The manual bit is not looked at in alarm mode, so a stale manual
    // setting cannot hold the coil on once the alarm function is chosen
    always @* begin
        aux_relay_nxt = 1'b0;
        case (relay_function_select)
            1'b0: begin
                aux_relay_nxt = relay_manual_state;
            end
            1'b1: begin
                aux_relay_nxt = hit;
            end
            default: begin
                aux_relay_nxt = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Bus answer

    always @* begin
        reg_ack_nxt   = 1'b0;
        reg_err_nxt   = 1'b0;
        reg_rdata_nxt = {DW{1'b0}};
        if (access_req) begin
            if (hit_sel) begin
                reg_ack_nxt = 1'b1;
            end else begin
                // Unknown location is flagged so the front end can reject it
                reg_err_nxt = 1'b1;
            end
        end
        // Read data is the word before any write of the same cycle
        if (rd_hit) begin
            reg_rdata_nxt = relay_config_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Registered outputs

    // The coil is driven from a flop so that config and flag changes
    // cannot glitch it; the price is one cycle of latency
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            aux_relay_o <= 1'b0;
        end else begin
            aux_relay_o <= aux_relay_nxt;
        end
    end

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            relay_config_o <= CFG_RST;
        end else begin
            relay_config_o <= relay_config_r;
        end
    end

    // Ack, error and read data each stand for one cycle per request
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            reg_ack_o <= 1'b0;
        end else begin
            reg_ack_o <= reg_ack_nxt;
        end
    end

    // The front end turns an error pulse into a rejected request
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            reg_err_o <= 1'b0;
        end else begin
            reg_err_o <= reg_err_nxt;
        end
    end

    // Zero outside a read hit, so a stale word is never mistaken for data
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= {DW{1'b0}};
        end else begin
            reg_rdata_o <= reg_rdata_nxt;
        end
    end

endmodule

`default_nettype wire

// ==== sim/rac_host_model.sv ====
// Host model: one-word register requests, launched at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module rac_host_model (
    input  wire logic        clk_i,
    output var  logic        wr_o, rd_o,
    output var  logic [15:0] addr_o, data_o
);
    initial {wr_o, rd_o, addr_o, data_o} = 34'h0;
    task automatic xfer(input logic [33:0] q);
        @(negedge clk_i) {wr_o, rd_o, addr_o, data_o} = q;
        // Strobes drop and address and data are inverted while idle so a stale word cannot pass for a live one
        @(negedge clk_i) {wr_o, rd_o, addr_o, data_o} = {2'b00, ~q[31:0]};
    endtask
endmodule
`default_nettype wire

// ==== sim/rac_relay_ctrl_assertions.sv ====
// Assertions on the relay controller ports.
`timescale 1ns/1ps
`default_nettype none
module rac_relay_ctrl_assertions (
    input wire logic        clk_i, rst_i, reg_wr_i, reg_rd_i, reg_ack_o, reg_err_o, aux_relay_o,
    input wire logic        internal_fault_flag_i, host_link_fault_flag_i, chain_bus_fault_flag_i,
    input wire logic        device_limit_fault_flag_i, device_mismatch_fault_flag_i,
    input wire logic        termination_fault_flag_i,
    input wire logic [15:0] reg_addr_i, reg_wdata_i, reg_rdata_o, relay_config_o
);
    wire logic [5:0] flags;
    assign flags = {termination_fault_flag_i, device_mismatch_fault_flag_i,
        device_limit_fault_flag_i, chain_bus_fault_flag_i, host_link_fault_flag_i,
        internal_fault_flag_i};
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence hit_s; reg_addr_i == 16'h0010 && (reg_wr_i || reg_rd_i); endsequence
    ack_hit_a: assert property (hit_s |=> reg_ack_o && !reg_err_o) else $error("no ack");
    err_miss_a: assert property (
        (reg_wr_i || reg_rd_i) && reg_addr_i != 16'h0010 |=> reg_err_o && !reg_ack_o)
        else $error("no error pulse");
    read_data_a: assert property (hit_s ##0 reg_rd_i |=> reg_rdata_o == relay_config_o)
        else $error("read data wrong");
    write_store_a: assert property (hit_s ##0 reg_wr_i |=> ##1
        relay_config_o == ($past(reg_wdata_i, 2) & 16'h00ff)) else $error("store wrong");
    bus_quiet_a: assert property (
        !reg_wr_i && !reg_rd_i |=> !reg_ack_o && !reg_err_o && reg_rdata_o == 16'h0000)
        else $error("spurious answer");
    reset_value_a: assert property ($fell(rst_i) |->
        relay_config_o == 16'h00fe && !aux_relay_o) else $error("reset value wrong");
    manual_drive_a: assert property (!$past(rst_i) && !relay_config_o[1] |->
        aux_relay_o == relay_config_o[0]) else $error("manual drive wrong");
    masked_off_a: assert property (!$past(rst_i) && relay_config_o[7:1] == 7'h01 |->
        !aux_relay_o) else $error("masked relay on");
    alarm_drive_a: assert property (!$past(rst_i) && relay_config_o[1] |->
        aux_relay_o == |($past(flags) & relay_config_o[7:2])) else $error("alarm drive wrong");
endmodule
bind rac_relay_ctrl rac_relay_ctrl_assertions chk_u (.*);
`default_nettype wire

// ==== sim/relay_alarm_output_ctrl_test.sv ====
// Bench: walked then random relay setups against alarm flags.
`timescale 1ns/1ps
`default_nettype none
module relay_alarm_output_ctrl_test;
    logic        clk_i = 0, rst_i = 1, w, r, k, x, y;
    logic [15:0] a, d, q, g, e;
    logic [5:0]  f = 0;
    int          n_fail = 0, tests_run = 0;
    initial forever #5 clk_i = ~clk_i;
    rac_host_model host_u (.clk_i, .wr_o(w), .rd_o(r), .addr_o(a), .data_o(d));
    rac_relay_ctrl dut_u (.clk_i, .rst_i, .reg_wr_i(w), .reg_rd_i(r), .reg_addr_i(a),
        .reg_wdata_i(d), .reg_rdata_o(q), .reg_ack_o(k), .reg_err_o(x),
        .internal_fault_flag_i(f[0]), .host_link_fault_flag_i(f[1]),
        .chain_bus_fault_flag_i(f[2]), .device_limit_fault_flag_i(f[3]),
        .device_mismatch_fault_flag_i(f[4]), .termination_fault_flag_i(f[5]),
        .aux_relay_o(y), .relay_config_o(g));
    function automatic logic relay_exp(input logic [15:0] c);
        return c[1] ? |(f & c[7:2]) : c[0];
    endfunction
    task automatic check(input string n, input logic [15:0] s, v);
        tests_run++;
        if (v !== s) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", n, s, v);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #20000 n_fail++;
        report_and_stop();
    end
    initial begin
        void'($urandom(32'he08f_493d));
        repeat (3) @(negedge clk_i);
        rst_i = 0;
        host_u.xfer({2'b01, 16'h0010, 16'h0000});
        check("read", 16'h00fe, q);
        check("ack", 16'h0001, 16'(k));
        check("read err", 16'h0000, 16'(x));
        host_u.xfer({2'b11, 16'h0011, 16'h0003});
        check("error", 16'h0001, 16'(x));
        check("miss ack", 16'h0000, 16'(k));
        check("miss data", 16'h0000, q);
        // Write and read in one cycle: old word comes back, new one is kept
        host_u.xfer({2'b11, 16'h0010, 16'hff01});
        check("read old", 16'h00fe, q);
        host_u.xfer({2'b01, 16'h0010, 16'h0000});
        check("read new", 16'h0001, q);
        check("manual on", 16'h0001, 16'(y));
        $display("test access done");
        // Alarm mode with every mask off and every flag raised
        host_u.xfer({2'b10, 16'h0010, 16'h0003});
        f = 6'h3f;
        @(negedge clk_i);
        check("all masked", 16'h0000, 16'(y));
        $display("test mask done");
        // Early passes walk one mask: its flag alone, then every other flag with bit 0 set
        for (int i = 0; i < 300; i++) begin
            e = i < 12 ? 16'h0002 | 16'(i % 2) | 16'h0004 << i / 2 : 16'($urandom);
            host_u.xfer({2'b10, 16'h0010, e});
            f = i < 12 ? 6'h01 << i / 2 ^ {6{i[0]}} : 6'($urandom);
            @(negedge clk_i);
            check("config", e & 16'h00ff, g);
            check("relay", 16'(relay_exp(e)), 16'(y));
        end
        $display("test relay done");
        // Reset in mid-run with one alarm pending: the default setup must catch it
        f = 6'h08;
        rst_i = 1;
        repeat (3) @(negedge clk_i);
        rst_i = 0;
        check("relay in reset", 16'h0000, 16'(y));
        host_u.xfer({2'b01, 16'h0010, 16'h0000});
        check("reset read", 16'h00fe, q);
        check("reset relay", 16'h0001, 16'(y));
        $display("test reset done");
        report_and_stop();
    end
endmodule
`default_nettype wire
